// File: hdl/batmon_defines.vh
// Constants shared by the battery monitor control block and its helpers.
// Assumes a 250 MHz system clock and a 32-bit classic Wishbone slave port.
`ifndef BATMON_DEFINES_VH
`define BATMON_DEFINES_VH

// Command word layout
`define CMD_W 6
`define CMD_OP_HI 5
`define CMD_OP_LO 4
`define CMD_ARG_HI 3
`define CMD_ARG_LO 0
`define OP_MONITOR 2'h0
`define OP_GAIN 2'h1
`define OP_OFFSET 2'h2
`define OP_POWER 2'h3
`define ARG_PD 4'hf
`define FET_CHG_BIT 1
`define FET_DIS_BIT 0

// Analog output selector codes
`define SEL_GND 4'h0
`define SEL_CUR 4'h1
`define SEL_CELL_FIRST 4'h2
`define SEL_CELL_LAST 4'h5

// Register map, byte addresses
`define ADR_W 4
`define ADR_STATUS 4'h0
`define ADR_INT 4'h4
`define ADR_MASK 4'h8
`define ADR_INJECT 4'hc

// Interrupt status bits
`define INT_W 4
`define INT_CMD 0
`define INT_OC 1
`define INT_PD 2
`define INT_WAKE 3

// Reset values
`define RST_SEL 4'h0
`define RST_GAIN 2'h0
`define RST_SHIFT 2'h0
`define RST_OFFSET 4'h0
`define RST_MASK 4'h0
// Synchroniser reset levels {sense, shift clock, strobe}: strobe idles high
`define SYNC_IDLE 3'h1

// Timing
`define CLK_MHZ 250
`define OC_DELAY_US 10000

`endif

// File: hdl/battery_monitor_serial_control.v
// Digital control of a four-cell battery monitor: serial command port,
// power-down sequencing, FET drives, overcurrent shut-off and Wishbone view.
// Assumes a 250 MHz clk_i, pins asynchronous to it, classic Wishbone master.
//
// Function
// RULE1 - Strobe low lets serial data shift in
// RULE2 - Shift clock rise shifts data bit in
// RULE3 - Strobe rise latches the shift register word
// RULE4 - Host sends exactly six bits per command
// RULE5 - Power-down command drives discharge FET off
// RULE6 - After power-down command, pull charger sense low
// RULE7 - Charger sense low then: supply off, power-down
// RULE8 - Power-down halts logic, both FETs held off
// RULE9 - Charger sense high wakes, supply on, commands
// RULE10 - Voltage monitoring disables part of current path
// RULE11 - Current monitoring disables voltage monitor path
// RULE12 - Host selects ground output when in standby
// RULE13 - Overcurrent turns discharge FET off after delay
// RULE14 - Commands set current gain and output shift
// RULE15 - Commands select voltage monitor offset correction
// RULE16 - Decode latched word into all actions
// RULE17 - After wake-up, analog selector at ground
//
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "batmon_defines.vh"
module battery_monitor_serial_control #(
  parameter OC_DELAY_CYC = `OC_DELAY_US * `CLK_MHZ,
  parameter CNT_W = 22
) (
  // System
  input wire clk_i,
  input wire rst_i,
  // Serial command port
  input wire load_strobe_i,
  input wire shift_clock_i,
  input wire serial_in_i,
  // Analog sense inputs
  input wire charger_sense_i,
  input wire overcurrent_i,
  // Wishbone slave
  input wire [`ADR_W-1:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg irq_o,
  // FET and supply controls
  output reg discharge_fet_drive_o,
  output reg charge_fet_drive_o,
  output reg supply_enable_o,
  output reg charger_pulldown_o,
  output reg delay_cap_node_o,
  // Analog configuration
  output reg [3:0] analog_sel_o,
  output reg voltage_path_en_o,
  output reg current_path_en_o,
  output reg [1:0] gain_sel_o,
  output reg [1:0] shift_sel_o,
  output reg [3:0] offset_sel_o
);
  // Power states, one-hot
  localparam ST_RUN = 3'b001;
  localparam ST_PEND = 3'b010;
  localparam ST_DOWN = 3'b100;

  reg [2:0] state_reg;
  reg [`CMD_W-1:0] cmd_reg;
  reg [3:0] sel_reg;
  reg [1:0] gain_reg;
  reg [1:0] shift_reg;
  reg [3:0] offset_reg;
  reg chg_off_reg;
  reg dis_off_reg;
  reg oc_trip_reg;
  reg [CNT_W-1:0] oc_cnt_reg;
  reg [`INT_W-1:0] int_reg;
  reg [`INT_W-1:0] int_next;
  reg [`INT_W-1:0] mask_reg;
  reg [`CMD_W-1:0] inject_reg;
  reg inject_reg_valid;

  wire [2:0] lvl;
  wire [2:0] rise;
  wire [2:0] fall;
  wire [`CMD_W-1:0] ser_word;
  wire ser_latch;
  wire run = state_reg[0];
  wire wb_hit = wb_cyc_i && wb_stb_i && wb_ack_o;
  wire wb_wr = wb_hit && wb_we_i && wb_sel_i[0];
  wire wb_rd = wb_hit && !wb_we_i;

  // Selector codes for one of the four cells
  function is_cell;
    input [3:0] sel;
    begin
      is_cell = (sel >= `SEL_CELL_FIRST) && (sel <= `SEL_CELL_LAST);
    end
  endfunction

  // Pins: strobe, shift clock and charger sense; data synced separately
  pin_sync #(.W(3), .IDLE(`SYNC_IDLE)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({charger_sense_i, shift_clock_i, load_strobe_i}),
    .level_o(lvl),
    .rise_o(rise),
    .fall_o(fall)
  );

  wire [1:0] misc_lvl;
  pin_sync #(.W(2)) u_sync_misc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({overcurrent_i, serial_in_i}),
    .level_o(misc_lvl),
    .rise_o(),
    .fall_o()
  );

  // Commands are taken only while running; the power-down path is halted
  serial_cmd_shifter u_shift (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .strobe_low_i(!lvl[0]), // RULE1
    .strobe_rise_i(rise[0]),
    .shift_rise_i(rise[1]), // RULE2
    .serial_bit_i(misc_lvl[0]),
    .accept_i(run),
    .word_o(ser_word),
    .latch_o(ser_latch)
  );

  // A serial latch has priority over an injected word in the same cycle
  wire cmd_go = run && (ser_latch || inject_reg_valid);
  wire [`CMD_W-1:0] cmd_word = ser_latch ? ser_word : inject_reg;
  wire [1:0] op = cmd_word[`CMD_OP_HI:`CMD_OP_LO];
  wire [3:0] arg = cmd_word[`CMD_ARG_HI:`CMD_ARG_LO];
  wire pd_cmd = cmd_go && (op == `OP_POWER) && (arg == `ARG_PD);
  wire oc_expire = run && !oc_trip_reg && misc_lvl[1] && (oc_cnt_reg == OC_DELAY_CYC[CNT_W-1:0] - 1'b1);
  wire pd_enter = state_reg[1] && !lvl[2];
  wire wake = state_reg[2] && lvl[2];

  // Power sequencing and command decode
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_RUN;
      cmd_reg <= {`CMD_W{1'b0}};
      sel_reg <= `RST_SEL;
      gain_reg <= `RST_GAIN;
      shift_reg <= `RST_SHIFT;
      offset_reg <= `RST_OFFSET;
      chg_off_reg <= 1'b1;
      dis_off_reg <= 1'b1;
    end
    else
    begin
      if (cmd_go)
        cmd_reg <= cmd_word;
      case (state_reg)
        ST_RUN:
        begin
          if (cmd_go)
          begin
            case (op) // RULE16
              `OP_MONITOR: sel_reg <= arg; // RULE12
              `OP_GAIN:
              begin
                gain_reg <= arg[3:2]; // RULE14
                shift_reg <= arg[1:0]; // RULE14
              end
              `OP_OFFSET: offset_reg <= arg; // RULE15
              default:
              begin
                if (arg == `ARG_PD)
                begin
                  dis_off_reg <= 1'b1; // RULE5
                  state_reg <= ST_PEND;
                end
                else
                begin
                  chg_off_reg <= arg[`FET_CHG_BIT];
                  dis_off_reg <= arg[`FET_DIS_BIT];
                end
              end
            endcase
          end
        end
        ST_PEND:
        begin
          if (pd_enter)
            state_reg <= ST_DOWN; // RULE7
        end
        ST_DOWN:
        begin
          chg_off_reg <= 1'b1; // RULE8
          dis_off_reg <= 1'b1; // RULE8
          if (wake)
          begin
            state_reg <= ST_RUN; // RULE9
            sel_reg <= `SEL_GND; // RULE17
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // Overcurrent delay; the trip holds until the host re-enables discharge with overcurrent gone, or the block leaves run
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      oc_cnt_reg <= {CNT_W{1'b0}};
      oc_trip_reg <= 1'b0;
    end
    else
    begin
      if (!run || !misc_lvl[1] || oc_trip_reg)
        oc_cnt_reg <= {CNT_W{1'b0}};
      else
        oc_cnt_reg <= oc_cnt_reg + 1'b1;
      if (oc_expire)
        oc_trip_reg <= 1'b1; // RULE13
      else if (!run || (cmd_go && op == `OP_POWER && arg != `ARG_PD && !arg[`FET_DIS_BIT] && !misc_lvl[1]))
        oc_trip_reg <= 1'b0;
    end
  end

  // Output drives, all registered
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      discharge_fet_drive_o <= 1'b1;
      charge_fet_drive_o <= 1'b1;
      supply_enable_o <= 1'b1;
      charger_pulldown_o <= 1'b0;
      delay_cap_node_o <= 1'b0;
      analog_sel_o <= `RST_SEL;
      voltage_path_en_o <= 1'b0;
      current_path_en_o <= 1'b0;
      gain_sel_o <= `RST_GAIN;
      shift_sel_o <= `RST_SHIFT;
      offset_sel_o <= `RST_OFFSET;
    end
    else
    begin
      discharge_fet_drive_o <= dis_off_reg || oc_trip_reg || !run; // RULE5 RULE13
      charge_fet_drive_o <= chg_off_reg || state_reg[2]; // RULE8
      supply_enable_o <= !state_reg[2]; // RULE7 RULE9
      charger_pulldown_o <= state_reg[1]; // RULE6
      delay_cap_node_o <= oc_trip_reg;
      analog_sel_o <= sel_reg;
      voltage_path_en_o <= run && is_cell(sel_reg); // RULE11
      current_path_en_o <= run && (sel_reg == `SEL_CUR); // RULE10
      gain_sel_o <= gain_reg;
      shift_sel_o <= shift_reg;
      offset_sel_o <= offset_reg;
    end
  end

  // Sticky events; a new event wins over the read that clears it
  always @*
  begin
    int_next = int_reg;
    if (wb_rd && wb_adr_i == `ADR_INT)
      int_next = {`INT_W{1'b0}};
    if (cmd_go)
      int_next[`INT_CMD] = 1'b1;
    if (oc_expire)
      int_next[`INT_OC] = 1'b1;
    if (pd_enter)
      int_next[`INT_PD] = 1'b1;
    if (wake)
      int_next[`INT_WAKE] = 1'b1;
  end

  // Wishbone slave: ack one cycle after request, writes at the ack edge
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      int_reg <= {`INT_W{1'b0}};
      mask_reg <= `RST_MASK;
      inject_reg <= {`CMD_W{1'b0}};
      inject_reg_valid <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      int_reg <= int_next;
      irq_o <= |(int_next & mask_reg);
      if (cmd_go && !ser_latch)
        inject_reg_valid <= 1'b0;
      if (wb_wr && wb_adr_i == `ADR_MASK)
        mask_reg <= wb_dat_i[`INT_W-1:0];
      if (wb_wr && wb_adr_i == `ADR_INJECT)
      begin
        inject_reg <= wb_dat_i[`CMD_W-1:0];
        inject_reg_valid <= 1'b1;
      end
      // Read data is ready in the same cycle as ack
      wb_dat_o <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i)
      begin
        case (wb_adr_i)
          `ADR_STATUS: wb_dat_o <= {22'h00_0000, oc_trip_reg, state_reg, cmd_reg};
          `ADR_INT: wb_dat_o <= {28'h000_0000, int_reg};
          `ADR_MASK: wb_dat_o <= {28'h000_0000, mask_reg};
          `ADR_INJECT: wb_dat_o <= {26'h000_0000, inject_reg};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: hdl/pin_sync.v
// Two-stage synchroniser for asynchronous pins, with edge detection.
// Assumes pins change slower than one clk_i period; edges use stage two only.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter W = 1,
  parameter [W-1:0] IDLE = {W{1'b0}}
) (
  // System
  input wire clk_i,
  input wire rst_i,
  // Pins
  input wire [W-1:0] pin_i,
  // Synchronised view
  output wire [W-1:0] level_o,
  output wire [W-1:0] rise_o,
  output wire [W-1:0] fall_o
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  reg [W-1:0] last_reg;

  // First stage feeds only the second one; reset to the idle level so
  // that leaving reset does not report a false edge on an idle pin
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= IDLE;
      sync_reg <= IDLE;
      last_reg <= IDLE;
    end
    else
    begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Edges compare stage two against its delayed copy
  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~last_reg;
  assign fall_o = ~sync_reg & last_reg;
endmodule
`default_nettype wire

// File: hdl/serial_cmd_shifter.v
// Six-bit serial command receiver working on sampled shift clock edges.
// Assumes synchronised strobe, clock edge and data from pin_sync.
`timescale 1ns/10ps
`default_nettype none
`include "batmon_defines.vh"
module serial_cmd_shifter (
  // System
  input wire clk_i,
  input wire rst_i,
  // Synchronised link
  input wire strobe_low_i,
  input wire strobe_rise_i,
  input wire shift_rise_i,
  input wire serial_bit_i,
  input wire accept_i,
  // Command out
  output reg [`CMD_W-1:0] word_o,
  output reg latch_o
);
  reg [`CMD_W-1:0] shift_reg;

  // Shift while strobe low, latch the word on its rising edge
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shift_reg <= {`CMD_W{1'b0}};
      word_o <= {`CMD_W{1'b0}};
      latch_o <= 1'b0;
    end
    else
    begin
      latch_o <= 1'b0;
      if (strobe_low_i && shift_rise_i) // RULE1
        shift_reg <= {shift_reg[`CMD_W-2:0], serial_bit_i}; // RULE2
      if (strobe_rise_i && accept_i)
      begin
        word_o <= shift_reg; // RULE3
        latch_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/batmon_asserts.sv
// Checker for the battery monitor control block, bound to its top module.
// Assumes only the top's ports; overcurrent time is counted in helper logic.
`timescale 1ns/10ps
`default_nettype none
`include "batmon_defines.vh"
module batmon_asserts #(
  parameter OC_DELAY_CYC = 50
) (
  // System
  input wire clk_i,
  input wire rst_i,
  // Watched ports
  input wire overcurrent_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire discharge_fet_drive_o,
  input wire charge_fet_drive_o,
  input wire supply_enable_o,
  input wire charger_pulldown_o,
  input wire delay_cap_node_o,
  input wire [3:0] analog_sel_o,
  input wire voltage_path_en_o,
  input wire current_path_en_o,
  input wire [1:0] gain_sel_o,
  input wire [3:0] offset_sel_o
);
  int oc_cnt;
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Raw pin count; saturates so a long overcurrent keeps the check armed.
  // Pending power-down does not count: discharge is already off there.
  always @(posedge clk_i)
    if (rst_i || !overcurrent_i || !supply_enable_o || charger_pulldown_o)
      oc_cnt <= 0;
    else if (oc_cnt < OC_DELAY_CYC + 8)
      oc_cnt <= oc_cnt + 1;

  chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_down_fets: assert property (!supply_enable_o |-> discharge_fet_drive_o && charge_fet_drive_o
    && !voltage_path_en_o && !current_path_en_o) else $error("power-down outputs");
  chk_down_pend: assert property ($fell(supply_enable_o) |-> $past(charger_pulldown_o))
    else $error("supply off without pending");
  chk_pend_dis: assert property (charger_pulldown_o |-> discharge_fet_drive_o)
    else $error("discharge on while pending");
  chk_wake_ground: assert property ($rose(supply_enable_o) |-> ##[0:2]
    (analog_sel_o == `SEL_GND && !charger_pulldown_o)) else $error("wake state");
  chk_paths_excl: assert property (!(voltage_path_en_o && current_path_en_o))
    else $error("both paths on");
  chk_cur_path: assert property (current_path_en_o |-> analog_sel_o == `SEL_CUR
    || $past(analog_sel_o) == `SEL_CUR) else $error("current path sel");
  chk_oc_trip: assert property (oc_cnt == OC_DELAY_CYC + 8 |-> discharge_fet_drive_o && delay_cap_node_o)
    else $error("no overcurrent trip");
  chk_trip_early: assert property ($rose(delay_cap_node_o) |-> oc_cnt >= OC_DELAY_CYC)
    else $error("trip too early");
  chk_halt_hold: assert property (!supply_enable_o |=> $stable(gain_sel_o) && $stable(offset_sel_o))
    else $error("settings moved while down");

  cov_down: cover property ($fell(supply_enable_o));
  cov_trip: cover property ($rose(delay_cap_node_o));
  cov_cur: cover property (current_path_en_o);
  cov_volt: cover property (voltage_path_en_o);
endmodule

bind battery_monitor_serial_control batmon_asserts #(.OC_DELAY_CYC(OC_DELAY_CYC)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .overcurrent_i(overcurrent_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .discharge_fet_drive_o(discharge_fet_drive_o), .charge_fet_drive_o(charge_fet_drive_o),
  .supply_enable_o(supply_enable_o), .charger_pulldown_o(charger_pulldown_o),
  .delay_cap_node_o(delay_cap_node_o), .analog_sel_o(analog_sel_o),
  .voltage_path_en_o(voltage_path_en_o), .current_path_en_o(current_path_en_o),
  .gain_sel_o(gain_sel_o), .offset_sel_o(offset_sel_o));
`default_nettype wire

// File: testbench/battery_monitor_serial_control_test.sv
// Self-checking bench for the battery monitor control block.
// Assumes host_serial_model on the serial pins and a Wishbone master here.
`timescale 1ns/10ps
`default_nettype none
`include "batmon_defines.vh"
module battery_monitor_serial_control_test;
  localparam int OCD = 50;
  logic clk_i, rst_i, charger_sense_i, overcurrent_i, wb_we_i, wb_cyc_i, wb_stb_i;
  logic [3:0] wb_adr_i, wb_sel_i, analog_sel_o, offset_sel_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [1:0] gain_sel_o, shift_sel_o;
  logic wb_ack_o, irq_o, dis_o, chg_o, sup_o, pd_o, trip_o, vp_o, cp_o, strobe, sclk, sdat;
  logic [7:0] w;
  int n_errors = 0, num_checks = 0, seed = 25, i;
  int m_sel, m_gain, m_shift, m_off, m_dis, m_chg, m_sup, m_pd;

  battery_monitor_serial_control #(.OC_DELAY_CYC(OCD)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .load_strobe_i(strobe), .shift_clock_i(sclk), .serial_in_i(sdat), .charger_sense_i(charger_sense_i),
    .overcurrent_i(overcurrent_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .discharge_fet_drive_o(dis_o), .charge_fet_drive_o(chg_o),
    .supply_enable_o(sup_o), .charger_pulldown_o(pd_o), .delay_cap_node_o(trip_o),
    .analog_sel_o(analog_sel_o), .voltage_path_en_o(vp_o), .current_path_en_o(cp_o),
    .gain_sel_o(gain_sel_o), .shift_sel_o(shift_sel_o), .offset_sel_o(offset_sel_o));
  host_serial_model host_u (.clk_i(clk_i), .load_strobe_o(strobe), .shift_clock_o(sclk),
    .serial_in_o(sdat));

  // 250 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic test_done;
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // Wait for ack however long it takes; only the watchdog ends a hang
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    check(nm, e, rd);
  endtask

  task automatic pins;
    check("sel", m_sel, analog_sel_o);
    check("gain", m_gain, gain_sel_o);
    check("shift", m_shift, shift_sel_o);
    check("offset", m_off, offset_sel_o);
    check("vpath", m_sup && !m_pd && m_sel >= 2 && m_sel <= 5, vp_o);
    check("cpath", m_sup && !m_pd && m_sel == 1, cp_o);
    check("dis", m_dis, dis_o);
    check("chg", m_chg, chg_o);
    check("supply", m_sup, sup_o);
    check("pulldown", m_pd, pd_o);
  endtask

  // Model takes only the last six bits and drops words unless running
  task automatic cmd(input logic [7:0] v, input int n);
    @(posedge clk_i);
    host_u.send(v, n);
    if (m_sup == 1 && m_pd == 0)
      case (v[5:4])
        `OP_MONITOR: m_sel = v[3:0];
        `OP_GAIN: {m_gain, m_shift} = {30'h0, v[3:2], 30'h0, v[1:0]};
        `OP_OFFSET: m_off = v[3:0];
        default: {m_pd, m_chg, m_dis} = (v[3:0] == `ARG_PD) ? {32'h1, m_chg, 32'h1} : {32'h0, 31'h0, v[1], 31'h0, v[0]};
      endcase
    repeat (16) @(posedge clk_i);
    pins;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    test_done;
  end

  initial
  begin
    {rst_i, charger_sense_i, overcurrent_i, wb_we_i, wb_cyc_i, wb_stb_i} = 6'h30;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h0;
    {m_sel, m_gain, m_shift, m_off, m_pd} = 160'h0;
    {m_dis, m_chg, m_sup} = {32'h1, 32'h1, 32'h1};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    pins;
    rd_chk("mask", `ADR_MASK, 32'h0);
    rd_chk("unmapped", 4'h2, 32'h0);
    wb(1'b1, `ADR_MASK, 32'h1, 4'hf);
    wb(1'b1, `ADR_MASK, 32'h0, 4'he);
    rd_chk("mask", `ADR_MASK, 32'h1);
    // Injected word acts like a serial one: offset command, argument 0xa
    wb(1'b1, `ADR_INJECT, 32'h0000_002a, 4'hf);
    m_off = 32'ha;
    rd_chk("inject", `ADR_INJECT, 32'h0000_002a);
    pins;
    // Every opcode, random arguments; power-down kept out here
    for (i = 0; i < 16; i++)
    begin
      w = 8'($random(seed));
      w[5:4] = 2'(i);
      if (w[5:4] == `OP_POWER && w[3:0] == `ARG_PD)
        w[3] = 1'b0;
      cmd(w, 6);
      check("irq", 1, irq_o);
      rd_chk("status", `ADR_STATUS, {26'h1, w[5:0]});
      rd_chk("int", `ADR_INT, 32'h1);
      repeat (2) @(posedge clk_i);
      check("irq", 0, irq_o);
    end
    cmd(8'h95, 8);
    cmd(8'h04, 6);
    cmd(8'h30, 6);
    overcurrent_i <= 1'b1;
    repeat (OCD - 10) @(posedge clk_i);
    check("dis", 0, dis_o);
    repeat (20) @(posedge clk_i);
    check("dis", 1, dis_o);
    check("trip", 1, trip_o);
    rd_chk("int", `ADR_INT, 32'h3);
    overcurrent_i <= 1'b0;
    cmd(8'h30, 6);
    check("trip", 0, trip_o);
    cmd(8'h3f, 6);
    cmd(8'h11, 6);
    charger_sense_i <= 1'b0;
    // Once down the pull-down is let go; supply off gates further commands
    {m_sup, m_dis, m_chg, m_pd} = {32'h0, 32'h1, 32'h1, 32'h0};
    repeat (8) @(posedge clk_i);
    pins;
    charger_sense_i <= 1'b1;
    {m_sup, m_sel, m_pd} = {32'h1, 32'h0, 32'h0};
    repeat (8) @(posedge clk_i);
    pins;
    rd_chk("int", `ADR_INT, 32'hd);
    cmd(8'h01, 6);
    cmd(8'h00, 6);
    test_done;
  end
endmodule
`default_nettype wire

// File: testbench/host_serial_model.sv
// Host side of the three-wire command port: strobe, shift clock, data.
// Assumes the 4 ns bench clock; the shift clock stands still outside frames.
`timescale 1ns/10ps
`default_nettype none
module host_serial_model (
  // System
  input wire logic clk_i,
  // Serial pins
  output logic load_strobe_o,
  output logic shift_clock_o,
  output logic serial_in_o
);
  // Idle: strobe high, clock low
  initial
  begin
    load_strobe_o = 1'b1;
    shift_clock_o = 1'b0;
    serial_in_o = 1'b0;
  end

  // Six clk_i per half period makes a 48 ns shift clock; first bit is the MSB
  task automatic send(input logic [7:0] w, input int n);
    int i;
    load_strobe_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    for (i = n - 1; i >= 0; i--)
    begin
      serial_in_o <= w[i];
      repeat (6) @(posedge clk_i);
      shift_clock_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      shift_clock_o <= 1'b0;
    end
    repeat (6) @(posedge clk_i);
    load_strobe_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    serial_in_o <= ~serial_in_o; // Toggle after the frame, so no stale bit stays on the line
  endtask
endmodule
`default_nettype wire
